// >>> logic/hbps_regs.svh
`ifndef HBPS_REGS_SVH
`define HBPS_REGS_SVH

// ----------------------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------------------
`define HBPS_CLK_MHZ       125
`define HBPS_PWM_KHZ       50
`define HBPS_PWM_CYCLES    ((`HBPS_CLK_MHZ * 1000) / `HBPS_PWM_KHZ)
`define HBPS_BLANK_NS      3750
`define HBPS_BLANK_CYCLES  ((`HBPS_BLANK_NS * `HBPS_CLK_MHZ + 999) / 1000)
`define HBPS_DEG_NS        2250
`define HBPS_DEG_CYCLES    ((`HBPS_DEG_NS * `HBPS_CLK_MHZ + 999) / 1000)
`define HBPS_DEAD_NS       450
`define HBPS_DEAD_CYCLES   ((`HBPS_DEAD_NS * `HBPS_CLK_MHZ + 999) / 1000)
`define HBPS_RETRY_US      1350
`define HBPS_RETRY_CYCLES  (`HBPS_RETRY_US * `HBPS_CLK_MHZ)
`define HBPS_WAKE_US       1000
`define HBPS_WAKE_CYCLES   (`HBPS_WAKE_US * `HBPS_CLK_MHZ)

// ----------------------------------------------------------------------------
// Thermal thresholds in degrees Celsius
// ----------------------------------------------------------------------------
`define HBPS_TSD_TRIP_C    8'h96
`define HBPS_TSD_HYST_C    8'h2d

// ----------------------------------------------------------------------------
// Gate vector bit positions
// ----------------------------------------------------------------------------
`define HBPS_G_HA          0
`define HBPS_G_LA          1
`define HBPS_G_HB          2
`define HBPS_G_LB          3
`define HBPS_GATES_OFF     4'h0

`endif

// >>> logic/hbps_pkg.sv
package hbps_pkg;

	typedef enum logic [1:0] {
		HBPS_COAST,
		HBPS_REVERSE,
		HBPS_FORWARD,
		HBPS_BRAKE
	} hbps_func_type;

	typedef enum logic {
		HBPS_RUN,
		HBPS_RETRY
	} hbps_ocp_type;

	typedef logic [3:0] hbps_gate_type;

endpackage

// >>> logic/hbps_timer.sv
`timescale 1ns/100ps
module hbps_timer #(
	parameter int LIMIT = 16
) (
	input  wire logic clk_i,
	input  wire logic clear_i,
	input  wire logic run_i,
	output logic      done_o
);
	localparam int W = $clog2(LIMIT + 1);

	logic [W-1:0] cnt;

	// Counts consecutive cycles of run_i; done_o rises after exactly LIMIT of them.
	always_ff @(posedge clk_i) begin
		if (clear_i || !run_i) begin
			cnt    <= '0;
			done_o <= 1'b0;
		end else if (!done_o) begin
			cnt    <= cnt + 1'b1;
			done_o <= (cnt == W'(LIMIT - 1));
		end
	end
endmodule

// >>> logic/hbps_gate.sv
`timescale 1ns/100ps
`include "hbps_regs.svh"
module hbps_gate (
	input  wire logic                   clk_i,
	input  wire logic                   clear_i,
	input  wire hbps_pkg::hbps_gate_type req_i,
	output hbps_pkg::hbps_gate_type      gate_o
);
	localparam int DEAD = `HBPS_DEAD_CYCLES;

	logic [6:0] cnt;

	wire going_off = (gate_o != `HBPS_GATES_OFF) || (req_i == `HBPS_GATES_OFF);
	wire dead_done = (cnt == 7'(DEAD - 1));

	// Every change passes through all-off for the dead time, so switching delay
	// in a leg never closes its high and its low side together.
	always_ff @(posedge clk_i) begin
		if (clear_i) begin
			gate_o <= `HBPS_GATES_OFF;
			cnt    <= '0;
		end else if (req_i == gate_o) begin
			cnt <= '0;
		end else if (going_off) begin
			gate_o <= `HBPS_GATES_OFF;
			cnt    <= '0;
		end else if (dead_done) begin
			gate_o <= req_i;
		end else begin
			cnt <= cnt + 1'b1;
		end
	end

	a_dead_gap: assert property (@(posedge clk_i) disable iff (clear_i)
		(gate_o != `HBPS_GATES_OFF) && ($past(gate_o) == `HBPS_GATES_OFF)
		|-> $past(gate_o, DEAD) == `HBPS_GATES_OFF)
		else $error("gate turned on before dead time elapsed");

	a_no_shoot: assert property (@(posedge clk_i) disable iff (clear_i)
		!(gate_o[`HBPS_G_HA] && gate_o[`HBPS_G_LA])
		&& !(gate_o[`HBPS_G_HB] && gate_o[`HBPS_G_LB]))
		else $error("high and low side of one leg on together");
endmodule

// >>> logic/hbps_ctrl.sv
`timescale 1ns/100ps
`include "hbps_regs.svh"
module hbps_ctrl #(
	parameter int WAKE_CYCLES  = `HBPS_WAKE_CYCLES,
	parameter int RETRY_CYCLES = `HBPS_RETRY_CYCLES
) (
	input  wire logic       clk_i,
	input  wire logic       reset_i,
	input  wire logic       low_power_request_n_i,
	input  wire logic       supply_low_lockout_i,
	input  wire logic [7:0] die_temp_i,
	input  wire logic [1:0] bridge_in_a_i,
	input  wire logic [1:0] bridge_in_b_i,
	input  wire logic [1:0] current_sense_pin_i,
	input  wire logic [1:0] overcurrent_guard_hs_i,
	input  wire logic [1:0] overcurrent_guard_ls_i,
	output logic [1:0]      high_side_a_o,
	output logic [1:0]      low_side_a_o,
	output logic [1:0]      high_side_b_o,
	output logic [1:0]      low_side_b_o,
	output logic            fault_out_n_o,
	output logic            charge_pump_en_o,
	output logic            ready_o
);
	localparam int BLANK = `HBPS_BLANK_CYCLES;
	localparam int DEG   = `HBPS_DEG_CYCLES;
	localparam int PWM   = `HBPS_PWM_CYCLES;

	// ------------------------------------------------------------------------
	// Sleep, lockout and wake-up
	// ------------------------------------------------------------------------
	// Sleep is modelled as a held logic reset; the clock itself is not gated
	// here, that belongs to the clock tree outside this block.
	wire sleep     = !low_power_request_n_i;
	wire logic_rst = reset_i || sleep || supply_low_lockout_i;
	wire awake     = ready_o && !logic_rst;
	logic hot;
	logic [11:0] pwm_cnt;
	hbps_pkg::hbps_gate_type gate_req [2];
	hbps_pkg::hbps_gate_type gate_now [2];
	hbps_pkg::hbps_gate_type normal_req [2];
	logic [1:0] chopped;
	logic [1:0] blank_done;
	logic [1:0] deg_done;
	logic [1:0] retry_done;
	hbps_pkg::hbps_ocp_type ocp_state [2];
	logic [1:0] ocp_any_q;

	hbps_timer #(
		.LIMIT(WAKE_CYCLES)
	) u_wake (
		.clk_i  (clk_i),
		.clear_i(logic_rst),
		.run_i  (1'b1),
		.done_o (ready_o)
	);

	always_ff @(posedge clk_i) begin
		if (logic_rst) begin
			charge_pump_en_o <= 1'b0;
		end else begin
			charge_pump_en_o <= 1'b1;
		end
	end

	// ------------------------------------------------------------------------
	// Thermal shutdown with hysteresis
	// ------------------------------------------------------------------------
	wire temp_trip  = die_temp_i >= `HBPS_TSD_TRIP_C;
	wire temp_clear = die_temp_i <= (`HBPS_TSD_TRIP_C - `HBPS_TSD_HYST_C);

	always_ff @(posedge clk_i) begin
		if (logic_rst) begin
			hot <= 1'b0;
		end else if (temp_trip) begin
			hot <= 1'b1;
		end else if (temp_clear) begin
			hot <= 1'b0;
		end
	end

	// ------------------------------------------------------------------------
	// Fixed-frequency PWM time base
	// ------------------------------------------------------------------------
	wire pwm_start = (pwm_cnt == 12'(PWM - 1));

	always_ff @(posedge clk_i) begin
		if (logic_rst || pwm_start) begin
			pwm_cnt <= '0;
		end else begin
			pwm_cnt <= pwm_cnt + 1'b1;
		end
	end

	// ------------------------------------------------------------------------
	// Per-bridge decode, chopping and overcurrent
	// ------------------------------------------------------------------------
	for (genvar i = 0; i < 2; i++) begin : g_bridge
		wire fwd       = bridge_in_a_i[i] && !bridge_in_b_i[i];
		wire rev       = !bridge_in_a_i[i] && bridge_in_b_i[i];
		wire brake     = bridge_in_a_i[i] && bridge_in_b_i[i];
		wire drive     = fwd || rev;
		wire ocp_any   = overcurrent_guard_hs_i[i] || overcurrent_guard_ls_i[i];
		wire ocp_run   = (ocp_state[i] == hbps_pkg::HBPS_RUN);
		wire enabled   = awake && !hot && ocp_run;
		wire chop_set  = drive && enabled && blank_done[i] && current_sense_pin_i[i]
			&& !pwm_start;
		wire chop_end  = pwm_start || !drive || !enabled;
		wire [3:0] ls_both = (4'h1 << `HBPS_G_LA) | (4'h1 << `HBPS_G_LB);
		wire [3:0] fwd_v   = (4'h1 << `HBPS_G_HA) | (4'h1 << `HBPS_G_LB);
		wire [3:0] rev_v   = (4'h1 << `HBPS_G_HB) | (4'h1 << `HBPS_G_LA);

		assign normal_req[i] = fwd ? fwd_v : rev ? rev_v : brake ? ls_both : `HBPS_GATES_OFF;
		assign gate_req[i] = !enabled ? `HBPS_GATES_OFF : chopped[i] ? ls_both : normal_req[i];

		// Blanking restarts whenever current is turned back on, which also
		// sets the shortest on-time that chopping can produce.
		hbps_timer #(
			.LIMIT(BLANK)
		) u_blank (
			.clk_i  (clk_i),
			.clear_i(logic_rst || pwm_start),
			.run_i  (drive && enabled && !chopped[i]),
			.done_o (blank_done[i])
		);

		always_ff @(posedge clk_i) begin
			if (logic_rst || chop_end) begin
				chopped[i] <= 1'b0;
			end else if (chop_set) begin
				chopped[i] <= 1'b1;
			end
		end

		hbps_timer #(
			.LIMIT(DEG)
		) u_deglitch (
			.clk_i  (clk_i),
			.clear_i(logic_rst),
			.run_i  (ocp_any && ocp_run && awake),
			.done_o (deg_done[i])
		);

		hbps_timer #(
			.LIMIT(RETRY_CYCLES)
		) u_retry (
			.clk_i  (clk_i),
			.clear_i(logic_rst),
			.run_i  (!ocp_run),
			.done_o (retry_done[i])
		);

		always_ff @(posedge clk_i) begin
			if (logic_rst) begin
				ocp_state[i] <= hbps_pkg::HBPS_RUN;
			end else begin
				unique case (ocp_state[i])
					hbps_pkg::HBPS_RUN: begin
						if (deg_done[i]) begin
							ocp_state[i] <= hbps_pkg::HBPS_RETRY;
						end
					end
					hbps_pkg::HBPS_RETRY: begin
						if (retry_done[i]) begin
							ocp_state[i] <= hbps_pkg::HBPS_RUN;
						end
					end
				endcase
			end
		end

		hbps_gate u_gate (
			.clk_i  (clk_i),
			.clear_i(reset_i),
			.req_i  (gate_req[i]),
			.gate_o (gate_now[i])
		);

		assign high_side_a_o[i] = gate_now[i][`HBPS_G_HA];
		assign low_side_a_o[i]  = gate_now[i][`HBPS_G_LA];
		assign high_side_b_o[i] = gate_now[i][`HBPS_G_HB];
		assign low_side_b_o[i]  = gate_now[i][`HBPS_G_LB];
	end

	// ------------------------------------------------------------------------
	// Fault output
	// ------------------------------------------------------------------------
	wire any_retry     = (ocp_state[0] != hbps_pkg::HBPS_RUN)
		|| (ocp_state[1] != hbps_pkg::HBPS_RUN);
	wire next_fault_n  = !(supply_low_lockout_i || hot || any_retry);

	always_ff @(posedge clk_i) begin
		if (reset_i || sleep) begin
			fault_out_n_o <= 1'b1;
		end else begin
			fault_out_n_o <= next_fault_n;
		end
	end

	// ------------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (reset_i);

	sequence s_shut_entry(int b);
		ocp_state[b] == hbps_pkg::HBPS_RUN ##1 ocp_state[b] == hbps_pkg::HBPS_RETRY;
	endsequence

	a_sleep_gates_off: assert property (
		sleep |=> (gate_now[0] == `HBPS_GATES_OFF) && (gate_now[1] == `HBPS_GATES_OFF)
			&& !charge_pump_en_o)
		else $error("gates or charge pump active during sleep");

	a_sleep_ignores: assert property (
		sleep |=> !ready_o ##1 !ready_o)
		else $error("block ready while asleep");

	a_wake_delay: assert property (
		$rose(ready_o) |-> $past(!logic_rst, 8) && $past(!logic_rst, 1))
		else $error("ready rose too early after wake");

	a_chop_slow_decay: assert property (
		chopped[0] && awake && !hot && ocp_state[0] == hbps_pkg::HBPS_RUN
		|-> gate_req[0] == ((4'h1 << `HBPS_G_LA) | (4'h1 << `HBPS_G_LB)))
		else $error("chopped bridge not in slow decay");

	a_chop_hold: assert property (
		chopped[0] && !pwm_start && !logic_rst && !hot
		&& ocp_state[0] == hbps_pkg::HBPS_RUN && (bridge_in_a_i[0] != bridge_in_b_i[0])
		|=> chopped[0])
		else $error("chop released before next PWM cycle");

	a_blank_ignore: assert property (
		$rose(chopped[0]) |-> $past(blank_done[0]) && $past(current_sense_pin_i[0]))
		else $error("sense used during blanking");

	a_ocp_trip: assert property (
		s_shut_entry(0) |-> $past(ocp_any_q[0], 2) ##1 !fault_out_n_o || sleep)
		else $error("overcurrent shutdown without cause or fault");

	a_ocp_local: assert property (
		ocp_state[0] == hbps_pkg::HBPS_RETRY && ocp_state[1] == hbps_pkg::HBPS_RUN
		&& awake && !hot && !chopped[1] |-> gate_req[1] == normal_req[1])
		else $error("healthy bridge disturbed by other bridge shutdown");

	a_retry_release: assert property (
		ocp_state[0] == hbps_pkg::HBPS_RETRY ##1 ocp_state[0] == hbps_pkg::HBPS_RUN
		|-> $past(retry_done[0]) || $past(logic_rst))
		else $error("bridge re-enabled before retry period");

	a_thermal_off: assert property (
		hot && !sleep |-> gate_req[0] == `HBPS_GATES_OFF ##1 !fault_out_n_o || sleep)
		else $error("transistors on or fault high while hot");

	a_thermal_hyst: assert property (
		hot && !logic_rst && !temp_clear |=> hot)
		else $error("thermal shutdown released without hysteresis");

	a_supply_low_lockout_fault: assert property (
		supply_low_lockout_i && !sleep |=> !fault_out_n_o && !ready_o)
		else $error("fault not low or logic not reset under lockout");

	always_ff @(posedge clk_i) begin
		ocp_any_q <= overcurrent_guard_hs_i | overcurrent_guard_ls_i;
	end
endmodule

// >>> tb/hbps_ctl_model.sv
`timescale 1ns/100ps
module hbps_ctl_model (
	input  wire logic       clk_i,
	input  wire logic       ready_i,
	input  wire logic [3:0] mode_i,
	output logic [1:0]      bridge_in_a_o,
	output logic [1:0]      bridge_in_b_o
);
	// ------------------------------------------------------------------
	// Controller side of the bridge inputs
	// ------------------------------------------------------------------
	// Coast is held until wake-up is reported, since drive asked for any
	// earlier would be dropped by the device anyway.
	always @(posedge clk_i) begin
		bridge_in_a_o <= ready_i ? {mode_i[3], mode_i[1]} : 2'h0;
		bridge_in_b_o <= ready_i ? {mode_i[2], mode_i[0]} : 2'h0;
	end
endmodule

// >>> tb/test_hbridge_protection_sleep_ctrl.sv
`timescale 1ns/100ps
module test_hbridge_protection_sleep_ctrl;
	localparam logic [3:0] OFF = 4'h0;
	localparam logic [3:0] REV = 4'h6;
	localparam logic [3:0] FWD = 4'h9;
	localparam logic [3:0] BRK = 4'h5;
	logic       clk_i   = 1'b0;
	logic       reset_i = 1'b1;
	logic       sleep_n = 1'b1;
	logic       supply_low_lockout    = 1'b0;
	logic [7:0] temp    = 8'h19;
	logic [3:0] mode    = 4'h0;
	logic [1:0] sense   = 2'h0;
	logic [1:0] ghs     = 2'h0;
	logic [1:0] gls     = 2'h0;
	logic [1:0] in_a, in_b, hsa, lsa, hsb, lsb;
	logic       fault_n, cp, ready;
	int         num_errors = 0;
	int         tests_run  = 0;
	int         cycles     = 0;

	always #4 clk_i = ~clk_i;

	hbps_ctrl #(.WAKE_CYCLES(20), .RETRY_CYCLES(30)) hbps_ctrl_i (
		.clk_i(clk_i), .reset_i(reset_i), .low_power_request_n_i(sleep_n),
		.supply_low_lockout_i(supply_low_lockout), .die_temp_i(temp), .bridge_in_a_i(in_a),
		.bridge_in_b_i(in_b), .current_sense_pin_i(sense),
		.overcurrent_guard_hs_i(ghs), .overcurrent_guard_ls_i(gls),
		.high_side_a_o(hsa), .low_side_a_o(lsa), .high_side_b_o(hsb),
		.low_side_b_o(lsb), .fault_out_n_o(fault_n), .charge_pump_en_o(cp),
		.ready_o(ready));

	hbps_ctl_model hbps_ctl_model_i (.clk_i(clk_i), .ready_i(ready), .mode_i(mode),
		.bridge_in_a_o(in_a), .bridge_in_b_o(in_b));

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	function automatic logic [3:0] g(input int b);
		return {hsa[b], lsa[b], hsb[b], lsb[b]};
	endfunction

	task automatic step(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask

	task automatic chk_gates(input int b, input logic [3:0] exp);
		tests_run++;
		if (g(b) !== exp) begin
			num_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g(b), exp);
		end
	endtask

	task automatic chk_flag(input logic got, input logic exp);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic results();
		$display("errors=%0d comparisons=%0d", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			results();
		end
	end

	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	task automatic t_wake();
		step(1);
		chk_flag(cp, 1'b1);
		step(10);
		chk_flag(ready, 1'b0);
		step(15);
		chk_flag(ready, 1'b1);
	endtask

	task automatic t_decode();
		logic [3:0] tab [4];
		tab = '{OFF, REV, FWD, BRK};
		for (int m = 0; m < 4; m++) begin
			@(posedge clk_i) mode <= {2'h0, m[1:0]};
			step(70);
			chk_gates(0, tab[m]);
		end
		@(posedge clk_i) mode <= 4'h2;
		step(70);
		@(posedge clk_i) mode <= 4'h1;
		step(30);
		chk_gates(0, OFF);
		step(40);
		chk_gates(0, REV);
		@(posedge clk_i) mode <= 4'h3;
		step(70);
		chk_gates(0, BRK);
	endtask

	task automatic t_ocp();
		@(posedge clk_i) mode <= 4'h6;
		step(70);
		@(posedge clk_i) gls[1] <= 1'b1;
		step(200);
		@(posedge clk_i) gls[1] <= 1'b0;
		step(1);
		chk_flag(fault_n, 1'b1);
		chk_gates(1, REV);
		@(posedge clk_i) ghs[0] <= 1'b1;
		step(270);
		chk_flag(fault_n, 1'b1);
		step(30);
		chk_flag(fault_n, 1'b0);
		chk_gates(0, OFF);
		chk_gates(1, REV);
		@(posedge clk_i) ghs[0] <= 1'b0;
		step(40);
		chk_flag(fault_n, 1'b1);
		step(70);
		chk_gates(0, FWD);
	endtask

	task automatic t_chop();
		@(posedge clk_i) mode <= 4'h0;
		step(5);
		@(posedge clk_i) mode <= 4'h2;
		sense[0] <= 1'b1;
		step(300);
		chk_gates(0, FWD);
		step(320);
		chk_gates(0, BRK);
		@(posedge clk_i) sense[0] <= 1'b0;
		for (int i = 0; i < 2700 && g(0) !== FWD; i++)
			step(1);
		chk_gates(0, FWD);
	endtask

	task automatic t_hot();
		@(posedge clk_i) temp <= 8'h95;
		step(5);
		chk_flag(fault_n, 1'b1);
		@(posedge clk_i) temp <= 8'h96;
		step(4);
		chk_flag(fault_n, 1'b0);
		chk_gates(0, OFF);
		@(posedge clk_i) temp <= 8'h6a;
		step(5);
		chk_flag(fault_n, 1'b0);
		@(posedge clk_i) temp <= 8'h69;
		step(4);
		chk_flag(fault_n, 1'b1);
		step(70);
		chk_gates(0, FWD);
	endtask

	task automatic t_supply_low_lockout();
		@(posedge clk_i) supply_low_lockout <= 1'b1;
		step(4);
		chk_flag(fault_n, 1'b0);
		chk_flag(ready, 1'b0);
		chk_gates(0, OFF);
		@(posedge clk_i) supply_low_lockout <= 1'b0;
		step(4);
		chk_flag(fault_n, 1'b1);
		step(25);
		chk_flag(ready, 1'b1);
	endtask

	task automatic t_sleep();
		@(posedge clk_i) sleep_n <= 1'b0;
		step(4);
		chk_flag(cp, 1'b0);
		chk_flag(ready, 1'b0);
		chk_gates(0, OFF);
		@(posedge clk_i) temp <= 8'hc8;
		ghs <= 2'h3;
		step(300);
		chk_flag(fault_n, 1'b1);
		@(posedge clk_i) temp <= 8'h19;
		ghs <= 2'h0;
		sleep_n <= 1'b1;
		t_wake();
		step(70);
		chk_gates(0, FWD);
	endtask

	initial begin
		step(4);
		@(posedge clk_i) reset_i <= 1'b0;
		t_wake();
		t_decode();
		t_ocp();
		t_chop();
		t_hot();
		t_supply_low_lockout();
		t_sleep();
		results();
	end
endmodule
